/* File: hw/fdp_config.sv */
// drive level, protection scheme and power-down depth configuration
// assumes spi mode 0 pins arrive asynchronously and sck stays well below clk/4
`default_nettype none

// How it works
// - drive level in bits 6:5 resets to 01; 00 reserved, 01/10/11 strengths (00 is stored as written here).
// - selected drive level goes to output drivers during reads; field read-write.
// - scheme bit 2 resets 0; at 0 region fields of first register protect.
// - scheme bit 1 protects through per-block lock bits instead.
// - all per-block lock bits read 1 after power-on or any reset.
// - with block scheme, 36h locks and 39h unlocks the addressed block.
// - depth bit 7 resets 0; then B9h acts as 79h, sram contents lost.
// - depth bit 1 makes B9h enter ordinary deep sleep, sram kept.
// - only command ABh leaves either power-down state.
// - toggling chip select alone never wakes the device.
module fdp_config (
  // clock and reset
  input  wire logic                        I_SYS_CLK,
  input  wire logic                        I_RESET,
  // spi pins
  input  wire logic                        I_SCK,
  input  wire logic                        I_CS_N,
  input  wire logic                        I_SI,
  output var  logic                        O_SO,
  output var  logic                        O_SO_OE_N,
  // output driver control
  output var  logic [1:0]                  O_DRIVE_LEVEL,
  // array protection
  input  wire logic [fdp_pkg::BLOCK_W-1:0] I_CHECK_BLOCK,
  output var  logic                        O_CHECK_LOCKED,
  output var  logic                        O_BLOCK_SCHEME,
  // power state
  output var  logic                        O_DEEP_SLEEP,
  output var  logic                        O_ULTRA_DEEP_SLEEP,
  output var  logic                        O_SRAM_CLEAR
);
  import fdp_pkg::*;

  logic                sck_m, sck_s, sck_p;
  logic                cs_m, cs_s, cs_p;
  logic                si_m, si_s;
  logic                sck_rise, sck_fall, cs_rise, selected;
  logic [7:0]          shift;
  logic [7:0]          next_byte;
  logic [2:0]          bit_cnt;
  logic [2:0]          byte_cnt;
  logic                byte_done;
  logic [7:0]          cmd;
  logic [23:0]         addr;
  fdp_frame_t          frame;
  fdp_power_t          power;
  logic [1:0]          output_drive_level;
  logic                protect_scheme_select;
  logic                power_down_depth_select;
  logic [7:0]          cfg3_view;
  logic [7:0]          cfg4_view;
  logic [7:0]          out_shift;
  logic                lock_wr;
  logic                single_done;

  // reads of either register show only the implemented bits
  function automatic logic [7:0] cfg3_image(input logic [1:0] drv, input logic sch);
    logic [7:0] v;
    v = 8'h00;
    v[DRV_MSB:DRV_LSB] = drv;
    v[SCHEME_BIT] = sch;
    return v;
  endfunction

  // which phase follows a completed opcode
  function automatic fdp_frame_t after_opcode(input logic [7:0] op, input logic asleep,
                                              input logic scheme);
    fdp_frame_t f;
    f = ST_IGNORE;
    if (asleep) begin
      f = ST_IGNORE;
    end else if (op == CMD_BLOCK_LOCK || op == CMD_BLOCK_UNLOCK) begin
      f = scheme ? ST_ADDR : ST_IGNORE;
    end else if (op == CMD_READ_CFG3 || op == CMD_READ_CFG4) begin
      f = ST_DATA;
    end else if (op == CMD_WRITE_CFG3 || op == CMD_WRITE_CFG4) begin
      f = ST_DATA;
    end
    return f;
  endfunction

  // two flops on every pin before any logic looks at it
  always_ff @(posedge I_SYS_CLK) begin
    if (I_RESET) begin
      sck_m <= 1'b0;
      sck_s <= 1'b0;
      sck_p <= 1'b0;
      cs_m  <= 1'b1;
      cs_s  <= 1'b1;
      cs_p  <= 1'b1;
      si_m  <= 1'b0;
      si_s  <= 1'b0;
    end else begin
      sck_m <= I_SCK;
      sck_s <= sck_m;
      sck_p <= sck_s;
      cs_m  <= I_CS_N;
      cs_s  <= cs_m;
      cs_p  <= cs_s;
      si_m  <= I_SI;
      si_s  <= si_m;
    end
  end

  assign sck_rise  = sck_s & ~sck_p;
  assign sck_fall  = ~sck_s & sck_p;
  assign cs_rise   = cs_s & ~cs_p;
  assign selected  = ~cs_s;
  assign next_byte = {shift[6:0], si_s};
  assign byte_done = selected & sck_rise & (bit_cnt == LAST_BIT);

  // bit and byte framing; deselect always restarts at the opcode
  always_ff @(posedge I_SYS_CLK) begin
    if (I_RESET || !selected) begin
      bit_cnt  <= 3'h0;
      byte_cnt <= 3'h0;
      shift    <= 8'h00;
    end else if (sck_rise) begin
      bit_cnt <= bit_cnt + 3'h1;
      shift   <= next_byte;
      if (bit_cnt == LAST_BIT && byte_cnt != BYTE_CAP) begin
        byte_cnt <= byte_cnt + 3'h1;
      end
    end
  end

  always_ff @(posedge I_SYS_CLK) begin
    if (I_RESET || !selected) begin
      frame <= ST_CMD;
    end else if (byte_done) begin
      case (frame)
        ST_CMD:  frame <= after_opcode(next_byte, power != PWR_ACTIVE,
                                       protect_scheme_select);
        ST_ADDR: frame <= (byte_cnt == 3'h3) ? ST_IGNORE : ST_ADDR;
        default: frame <= frame;
      endcase
    end
  end

  always_ff @(posedge I_SYS_CLK) begin
    if (I_RESET) begin
      cmd  <= 8'h00;
      addr <= 24'h000000;
    end else if (byte_done) begin
      if (frame == ST_CMD) begin
        cmd <= next_byte;
      end else if (frame == ST_ADDR) begin
        addr <= {addr[15:0], next_byte};
      end
    end
  end

  // register writes take the first data byte; later bytes are ignored
  always_ff @(posedge I_SYS_CLK) begin
    if (I_RESET) begin
      output_drive_level      <= DRV_RESET;
      protect_scheme_select   <= SCHEME_RESET;
      power_down_depth_select <= DEPTH_RESET;
    end else if (byte_done && frame == ST_DATA && byte_cnt == ONE_BYTE) begin
      if (cmd == CMD_WRITE_CFG3) begin
        // reserved bit positions are simply not stored
        output_drive_level    <= next_byte[DRV_MSB:DRV_LSB];
        protect_scheme_select <= next_byte[SCHEME_BIT];
      end else if (cmd == CMD_WRITE_CFG4) begin
        power_down_depth_select <= next_byte[DEPTH_BIT];
      end
    end
  end

  assign cfg3_view = cfg3_image(output_drive_level, protect_scheme_select);
  assign cfg4_view = {power_down_depth_select, 7'h00};

  // read data: rotate so a long read repeats the register value
  always_ff @(posedge I_SYS_CLK) begin
    if (I_RESET) begin
      out_shift <= 8'h00;
      O_SO      <= 1'b0;
    end else if (byte_done && frame == ST_CMD) begin
      out_shift <= (next_byte == CMD_READ_CFG4) ? cfg4_view : cfg3_view;
    end else if (sck_fall && selected && frame == ST_DATA &&
                 (cmd == CMD_READ_CFG3 || cmd == CMD_READ_CFG4)) begin
      O_SO      <= out_shift[7];
      out_shift <= {out_shift[6:0], out_shift[7]};
    end
  end

  // drive only while returning read data, at the selected strength
  always_ff @(posedge I_SYS_CLK) begin
    if (I_RESET) begin
      O_SO_OE_N <= 1'b1;
    end else begin
      O_SO_OE_N <= ~(selected && frame == ST_DATA &&
                     (cmd == CMD_READ_CFG3 || cmd == CMD_READ_CFG4));
    end
  end

  assign O_DRIVE_LEVEL  = output_drive_level;
  assign O_BLOCK_SCHEME = protect_scheme_select;

  // one-byte commands act only on a clean deselect after exactly eight bits
  assign single_done = cs_rise && byte_cnt == ONE_BYTE && bit_cnt == 3'h0;

  // a partial frame is discarded, so the address is always complete here
  assign lock_wr = cs_rise && protect_scheme_select && power == PWR_ACTIVE &&
                   byte_cnt == ADDR_DONE && bit_cnt == 3'h0 &&
                   (cmd == CMD_BLOCK_LOCK || cmd == CMD_BLOCK_UNLOCK);

  fdp_lock_mem u_lock_mem (
    .i_clk    (I_SYS_CLK),
    .i_reset  (I_RESET),
    .i_wr_en  (lock_wr),
    .i_wr_idx (addr[BLOCK_ADDR_LSB +: BLOCK_W]),
    .i_wr_val (cmd == CMD_BLOCK_LOCK),
    .i_rd_idx (I_CHECK_BLOCK),
    .o_rd_val (O_CHECK_LOCKED)
  );

  // power state; chip select activity by itself never changes it
  always_ff @(posedge I_SYS_CLK) begin
    if (I_RESET) begin
      power <= PWR_ACTIVE;
    end else if (single_done) begin
      case (power)
        PWR_ACTIVE: begin
          if (cmd == CMD_ULTRA_SLEEP) begin
            power <= PWR_ULTRA;
          end else if (cmd == CMD_DEEP_SLEEP) begin
            power <= power_down_depth_select ? PWR_DEEP : PWR_ULTRA;
          end
        end
        default: begin
          if (cmd == CMD_WAKE) begin
            power <= PWR_ACTIVE;
          end
        end
      endcase
    end
  end

  // sram loses its contents only on the ultra-deep entry
  always_ff @(posedge I_SYS_CLK) begin
    if (I_RESET) begin
      O_SRAM_CLEAR <= 1'b0;
    end else begin
      O_SRAM_CLEAR <= single_done && power == PWR_ACTIVE &&
                      (cmd == CMD_ULTRA_SLEEP ||
                       (cmd == CMD_DEEP_SLEEP && !power_down_depth_select));
    end
  end

  assign O_DEEP_SLEEP       = (power == PWR_DEEP);
  assign O_ULTRA_DEEP_SLEEP = (power == PWR_ULTRA);
endmodule
`default_nettype wire

/* File: hw/fdp_pkg.sv */
// constants for the drive / protect / power-down configuration block
// assumes a single 250 MHz system clock and spi pins sampled by it
`default_nettype none
package fdp_pkg;
  // command opcodes
  localparam logic [7:0] CMD_BLOCK_LOCK      = 8'h36;
  localparam logic [7:0] CMD_BLOCK_UNLOCK    = 8'h39;
  localparam logic [7:0] CMD_DEEP_SLEEP      = 8'hb9;
  localparam logic [7:0] CMD_ULTRA_SLEEP     = 8'h79;
  localparam logic [7:0] CMD_WAKE            = 8'hab;
  localparam logic [7:0] CMD_READ_CFG3       = 8'h15;
  localparam logic [7:0] CMD_READ_CFG4       = 8'h45;
  localparam logic [7:0] CMD_WRITE_CFG3      = 8'h11;
  localparam logic [7:0] CMD_WRITE_CFG4      = 8'h71;
  // drive_and_protect_config fields
  localparam int         DRV_MSB             = 6;
  localparam int         DRV_LSB             = 5;
  localparam int         SCHEME_BIT          = 2;
  localparam logic [1:0] DRV_RESET           = 2'h1;
  localparam logic [1:0] DRV_RESERVED        = 2'h0;
  localparam logic       SCHEME_RESET        = 1'b0;
  // power_down_config fields
  localparam int         DEPTH_BIT           = 7;
  localparam logic       DEPTH_RESET         = 1'b0;
  // block lock array: one lock bit per 64 kB block
  localparam int         BLOCK_W             = 6;
  localparam int         BLOCK_N             = 64;
  localparam int         BLOCK_ADDR_LSB      = 16;
  localparam logic       LOCK_RESET          = 1'b1;
  // frame byte counts and last bit index
  localparam logic [2:0] ONE_BYTE            = 3'h1;
  localparam logic [2:0] ADDR_DONE           = 3'h4;
  localparam logic [2:0] BYTE_CAP            = 3'h7;
  localparam logic [2:0] LAST_BIT            = 3'h7;

  typedef enum logic [1:0] {ST_CMD, ST_ADDR, ST_DATA, ST_IGNORE} fdp_frame_t;
  typedef enum logic [1:0] {PWR_ACTIVE, PWR_DEEP, PWR_ULTRA} fdp_power_t;
endpackage
`default_nettype wire

/* File: hw/fdp_lock_mem.sv */
// per-block lock bits with one write port and one registered read port
// assumes writes come from the command decoder on the same clock
`default_nettype none
module fdp_lock_mem (
  // clock and reset
  input  wire logic                       i_clk,
  input  wire logic                       i_reset,
  // write port
  input  wire logic                       i_wr_en,
  input  wire logic [fdp_pkg::BLOCK_W-1:0] i_wr_idx,
  input  wire logic                       i_wr_val,
  // read port
  input  wire logic [fdp_pkg::BLOCK_W-1:0] i_rd_idx,
  output var  logic                       o_rd_val
);
  import fdp_pkg::*;

  logic [BLOCK_N-1:0] lock;

  // every block comes up locked
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      lock <= {BLOCK_N{LOCK_RESET}};
    end else if (i_wr_en) begin
      lock[i_wr_idx] <= i_wr_val;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_rd_val <= LOCK_RESET;
    end else begin
      o_rd_val <= lock[i_rd_idx];
    end
  end
endmodule
`default_nettype wire

/* File: verification/fdp_host_model.sv */
// host spi master model driving the config block pins
// assumes spi mode 0 and the 250 MHz system clock on i_clk
`default_nettype none
module fdp_host_model (
  // clock
  input  wire logic i_clk,
  // spi pins
  input  wire logic i_so,
  output var  logic o_sck,
  output var  logic o_cs_n,
  output var  logic o_si
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    o_sck = 1'b0;
    o_cs_n = 1'b1;
    o_si = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
  endtask
  // bits go out msb first from d[31]; sck idles low outside frames
  task automatic xfer(input logic [31:0] d, input int n, output logic [7:0] rd);
    rd = 8'h00;
    @(posedge i_clk);
    o_cs_n <= 1'b0;
    for (int i = 0; i < n; i++) begin
      tick(1);
      o_si <= d[31-i];
      tick(4);
      rd = {rd[6:0], i_so};
      o_sck <= 1'b1;
      tick(4);
      o_sck <= 1'b0;
    end
    tick(4);
    o_cs_n <= 1'b1;
    // released line must not keep showing the last bit
    o_si <= ~o_si;
    tick(6);
  endtask
endmodule
`default_nettype wire

/* File: verification/fdp_config_monitor.sv */
// port assertions for the config block
// assumes one clock domain and a synchronous active-high reset
`default_nettype none
module fdp_config_monitor (
  // clock and reset
  input wire logic       I_SYS_CLK,
  input wire logic       I_RESET,
  // pins and state
  input wire logic       I_CS_N,
  input wire logic       O_SO_OE_N,
  input wire logic [1:0] O_DRIVE_LEVEL,
  input wire logic       O_CHECK_LOCKED,
  input wire logic       O_BLOCK_SCHEME,
  input wire logic       O_DEEP_SLEEP,
  input wire logic       O_ULTRA_DEEP_SLEEP,
  input wire logic       O_SRAM_CLEAR
);
  default clocking @(posedge I_SYS_CLK);
  endclocking
  default disable iff (I_RESET);
  sequence s_clear_pulse;
    O_SRAM_CLEAR ##1 !O_SRAM_CLEAR;
  endsequence
  sequence s_asleep_idle;
    (O_DEEP_SLEEP || O_ULTRA_DEEP_SLEEP) && I_CS_N;
  endsequence
  chk_drv_reset: assert property (
    $fell(I_RESET) |-> O_DRIVE_LEVEL == 2'h1) else $error("drive level not 01 after reset");
  chk_scheme_reset: assert property (
    $fell(I_RESET) |-> !O_BLOCK_SCHEME) else $error("scheme set after reset");
  chk_lock_reset: assert property (
    $fell(I_RESET) |-> O_CHECK_LOCKED [*2]) else $error("block unlocked after reset");
  chk_sleep_reset: assert property (
    $fell(I_RESET) |-> !O_DEEP_SLEEP && !O_ULTRA_DEEP_SLEEP && !O_SRAM_CLEAR)
    else $error("asleep after reset");
  chk_clear_on_ultra: assert property (
    O_SRAM_CLEAR |-> $rose(O_ULTRA_DEEP_SLEEP) ##0 s_clear_pulse)
    else $error("sram clear without ultra entry");
  chk_deep_keeps_sram: assert property (
    $rose(O_DEEP_SLEEP) |-> !O_SRAM_CLEAR && !O_ULTRA_DEEP_SLEEP)
    else $error("deep entry lost sram");
  chk_stay_asleep: assert property (
    s_asleep_idle [*6] |=> O_DEEP_SLEEP || O_ULTRA_DEEP_SLEEP)
    else $error("woke without a frame");
  chk_oe_release: assert property (
    $rose(I_CS_N) |-> ##[1:6] O_SO_OE_N) else $error("so still driven after frame");
  chk_oe_in_frame: assert property (
    $fell(O_SO_OE_N) |-> !I_CS_N) else $error("so driven outside frame");
  chk_cfg_in_frame: assert property (
    ($changed(O_DRIVE_LEVEL) || $changed(O_BLOCK_SCHEME)) && !$past(I_RESET)
    |-> !$past(I_CS_N, 3)) else $error("config changed outside frame");
endmodule
bind fdp_config fdp_config_monitor u_monitor (
  .I_SYS_CLK(I_SYS_CLK), .I_RESET(I_RESET), .I_CS_N(I_CS_N), .O_SO_OE_N(O_SO_OE_N),
  .O_DRIVE_LEVEL(O_DRIVE_LEVEL), .O_CHECK_LOCKED(O_CHECK_LOCKED),
  .O_BLOCK_SCHEME(O_BLOCK_SCHEME), .O_DEEP_SLEEP(O_DEEP_SLEEP),
  .O_ULTRA_DEEP_SLEEP(O_ULTRA_DEEP_SLEEP), .O_SRAM_CLEAR(O_SRAM_CLEAR));
`default_nettype wire

/* File: verification/fdp_config_bench.sv */
// self-checking bench for the config block
// assumes the host model owns the spi pins
`default_nettype none
module fdp_config_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import fdp_pkg::*;
  logic clk, rst, sck, cs_n, si, so, oe_n, lck, sch, deep, ultra, clr;
  logic [1:0] drv;
  logic [BLOCK_W-1:0] blk;
  logic [7:0] rd;
  int failures, comparisons, clears;
  fdp_config u_dut (.I_SYS_CLK(clk), .I_RESET(rst), .I_SCK(sck), .I_CS_N(cs_n),
    .I_SI(si), .O_SO(so), .O_SO_OE_N(oe_n), .O_DRIVE_LEVEL(drv), .I_CHECK_BLOCK(blk),
    .O_CHECK_LOCKED(lck), .O_BLOCK_SCHEME(sch), .O_DEEP_SLEEP(deep),
    .O_ULTRA_DEEP_SLEEP(ultra), .O_SRAM_CLEAR(clr));
  fdp_host_model u_host (.i_clk(clk), .i_so(so), .o_sck(sck), .o_cs_n(cs_n), .o_si(si));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) if (clr === 1'b1) clears++;
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic results;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic do_reset;
    @(posedge clk);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
  endtask
  task automatic send(input logic [7:0] op, input logic [7:0] arg, input int n);
    u_host.xfer({op, arg, 16'h0}, n, rd);
  endtask
  task automatic peek(input logic [5:0] b, input logic exp);
    blk <= b;
    repeat (2) @(posedge clk);
    #1 check({7'h0, lck}, {7'h0, exp});
  endtask
  // sleep state as {deep, ultra}; sram losses counted by clears
  task automatic sleep_is(input logic [1:0] s, input int c);
    check({6'h0, deep, ultra}, {6'h0, s});
    check(clears[7:0], c[7:0]);
  endtask
  initial begin
    repeat (100000) @(posedge clk);
    failures++;
    results();
  end
  initial begin
    rst = 1'b1;
    blk = '0;
    do_reset();
    check({6'h0, drv}, {6'h0, DRV_RESET});
    send(CMD_READ_CFG3, 8'h0, 16);
    check(rd, 8'h20);
    send(CMD_READ_CFG4, 8'h0, 16);
    check(rd, 8'h00);
    send(CMD_BLOCK_UNLOCK, 8'h09, 32);
    peek(6'd9, 1'b1);
    for (int d = 0; d < 4; d++) begin
      send(CMD_WRITE_CFG3, {1'b1, d[1:0], 5'h1f}, 16);
      check({6'h0, drv}, {6'h0, d[1:0]});
      send(CMD_READ_CFG3, 8'h0, 16);
      check(rd, {1'b0, d[1:0], 5'h04});
    end
    send(CMD_BLOCK_UNLOCK, 8'h09, 32);
    peek(6'd9, 1'b0);
    peek(6'd10, 1'b1);
    send(CMD_BLOCK_LOCK, 8'h09, 32);
    peek(6'd9, 1'b1);
    send(CMD_BLOCK_UNLOCK, 8'h3f, 32);
    peek(6'd63, 1'b0);
    do_reset();
    peek(6'd63, 1'b1);
    check({5'h0, drv, sch}, 8'h02);
    send(CMD_DEEP_SLEEP, 8'h0, 8);
    sleep_is(2'b01, 1);
    u_host.xfer(32'h0, 0, rd); // chip select toggled alone
    send(CMD_WRITE_CFG4, 8'h80, 16);
    sleep_is(2'b01, 1);
    send(CMD_WAKE, 8'h0, 8);
    sleep_is(2'b00, 1);
    send(CMD_READ_CFG4, 8'h0, 16);
    check(rd, 8'h00);
    send(CMD_WRITE_CFG4, 8'hff, 16);
    send(CMD_READ_CFG4, 8'h0, 16);
    check(rd, 8'h80);
    send(CMD_DEEP_SLEEP, 8'h0, 8);
    sleep_is(2'b10, 1);
    send(CMD_ULTRA_SLEEP, 8'h0, 8);
    sleep_is(2'b10, 1);
    send(CMD_WAKE, 8'h0, 8);
    sleep_is(2'b00, 1);
    send(CMD_ULTRA_SLEEP, 8'h0, 8);
    sleep_is(2'b01, 2);
    send(CMD_WAKE, 8'h0, 8);
    sleep_is(2'b00, 2);
    results();
  end
endmodule
`default_nettype wire
